/* rtl/dtf_timers.sv */
// Purpose: Two 16-bit counter/timers, four modes on A, three on B (B holds its count in mode 3)
// Assumes: Plain register port, inputs sampled on clk_sys_i
// Notes: Read data appear only in the cycle after the read strobe
`timescale 1ns/10ps
module dtf_timers (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // External pins
  input wire logic count_pin_a_i,
  input wire logic count_pin_b_i,
  input wire logic gating_input_a_i,
  input wire logic gating_input_b_i,
  input wire logic ext_clk_i,
  // Requests and overflow
  output logic irq_req_a_o,
  output logic irq_req_b_o,
  output logic ovf_b_o
);

  // ******************************************************************
  // Count step helper
  // ******************************************************************

  // Advance one count; returns {overflow, high, low}
  function automatic logic [16:0] dtf_step(input logic [1:0] mode,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [13:0] v13;
    logic [16:0] v16;
    logic [8:0] v8;
    logic [16:0] r;
    v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    v16 = {1'b0, hi, lo} + 17'h00001;
    v8 = {1'b0, lo} + 9'h001;
    r = {1'b0, hi, lo};
    unique case (mode)
      dtf_pkg::MODE_13BIT: begin
        // Upper low-byte bits left alone
        r = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
      end
      dtf_pkg::MODE_16BIT: begin
        r = v16;
      end
      dtf_pkg::MODE_RELOAD: begin
        // Wrap reloads low from high, high untouched
        r = v8[8] ? {1'b1, hi, hi} : {1'b0, hi, v8[7:0]};
      end
      dtf_pkg::MODE_SPLIT: begin
        r = {1'b0, hi, lo};
      end
    endcase
    return r;
  endfunction

  // Pick the count source for a timer
  function automatic logic dtf_src(input logic cs, input logic sys,
                                   input logic ext_fall,
                                   input logic pre_tick);
    logic t;
    t = cs ? ext_fall : (sys ? 1'b1 : pre_tick);
    return t;
  endfunction

  // ******************************************************************
  // State
  // ******************************************************************
  logic [7:0] lo_a_q, lo_a_d, hi_a_q, hi_a_d;
  logic [7:0] lo_b_q, lo_b_d, hi_b_q, hi_b_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] scale_q, scale_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] ext_cfg_q, ext_cfg_d;
  logic [7:0] rdata_q, rdata_d;
  logic ovf_b_q, ovf_b_d;

  // Synchronised pins
  logic [4:0] pin_level, pin_fall;
  logic fall_a, fall_b, gin_a, gin_b, pre_tick;

  // Decoded controls
  logic [1:0] mode_a, mode_b;
  logic run_a, run_b, gate_a, gate_b, cs_a, cs_b;
  logic sys_a, sys_b, pol_a, pol_b;
  logic en_a, en_b, tick_a, tick_b, tick_hi;
  logic split;
  logic [16:0] step_a, step_b;
  logic [8:0] inc_lo_a, inc_hi_a;
  logic set_tf_a, set_tf_b, ovf_b_evt;

  // ******************************************************************
  // Input synchronisers and prescaler
  // ******************************************************************

  // All pins pass through the synchroniser
  dtf_edge_sync #(
    .W(5)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i({ext_clk_i, gating_input_b_i, gating_input_a_i,
              count_pin_b_i, count_pin_a_i}),
    .level_o(pin_level),
    .fall_o(pin_fall)
  );

  assign fall_a = pin_fall[0];
  assign fall_b = pin_fall[1];
  assign gin_a = pin_level[2];
  assign gin_b = pin_level[3];

  // Shared prescaled clock tick
  dtf_prescaler u_pre (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .scale_i(scale_q[dtf_pkg::SCALE_PRE +: 2]),
    .ext_fall_i(pin_fall[4]),
    .tick_o(pre_tick)
  );

  // ******************************************************************
  // Control decode
  // ******************************************************************

  // Field extraction
  always_comb begin
    mode_a = mode_q[dtf_pkg::MODE_SEL_A +: 2];
    mode_b = mode_q[dtf_pkg::MODE_SEL_B +: 2];
    gate_a = mode_q[dtf_pkg::MODE_GATE_A];
    gate_b = mode_q[dtf_pkg::MODE_GATE_B];
    cs_a = mode_q[dtf_pkg::MODE_CS_A];
    cs_b = mode_q[dtf_pkg::MODE_CS_B];
    run_a = ctrl_q[dtf_pkg::CTRL_RUN_A];
    run_b = ctrl_q[dtf_pkg::CTRL_RUN_B];
    sys_a = scale_q[dtf_pkg::SCALE_SYS_A];
    sys_b = scale_q[dtf_pkg::SCALE_SYS_B];
    pol_a = ext_cfg_q[dtf_pkg::EXT_POL_A];
    pol_b = ext_cfg_q[dtf_pkg::EXT_POL_B];
    split = (mode_a == dtf_pkg::MODE_SPLIT);
  end

  // Run gating
  always_comb begin
    en_a = run_a && (!gate_a || (gin_a == pol_a));
    en_b = run_b && (!gate_b || (gin_b == pol_b));
    tick_a = dtf_src(cs_a, sys_a, fall_a, pre_tick);
    tick_b = dtf_src(cs_b, sys_b, fall_b, pre_tick);
    // Split high byte never counts edges
    tick_hi = dtf_src(1'b0, sys_a, 1'b0, pre_tick);
  end

  // ******************************************************************
  // Counting and register next state
  // ******************************************************************

  // Next values for counts, flags and registers
  always_comb begin
    lo_a_d = lo_a_q;
    hi_a_d = hi_a_q;
    lo_b_d = lo_b_q;
    hi_b_d = hi_b_q;
    ctrl_d = ctrl_q;
    mode_d = mode_q;
    scale_d = scale_q;
    mask_d = mask_q;
    ext_cfg_d = ext_cfg_q;
    set_tf_a = 1'b0;
    set_tf_b = 1'b0;
    ovf_b_evt = 1'b0;
    step_a = dtf_step(mode_a, lo_a_q, hi_a_q);
    step_b = dtf_step(mode_b, lo_b_q, hi_b_q);
    inc_lo_a = {1'b0, lo_a_q} + 9'h001;
    inc_hi_a = {1'b0, hi_a_q} + 9'h001;

    // Timer A
    if (split) begin
      // Low byte with timer A controls
      if (en_a && tick_a) begin
        lo_a_d = inc_lo_a[7:0];
        set_tf_a = inc_lo_a[8];
      end
      // High byte on timer B run bit and flag
      if (run_b && tick_hi) begin
        hi_a_d = inc_hi_a[7:0];
        set_tf_b = inc_hi_a[8];
      end
    end else if (en_a && tick_a) begin
      {hi_a_d, lo_a_d} = step_a[15:0];
      set_tf_a = step_a[16];
    end

    // Timer B
    if (split) begin
      // Runs by mode alone, no edges, no flag
      if ((mode_b != dtf_pkg::MODE_SPLIT) &&
          dtf_src(1'b0, sys_b, 1'b0, pre_tick)) begin
        {hi_b_d, lo_b_d} = step_b[15:0];
        ovf_b_evt = step_b[16];
      end
    end else if ((mode_b != dtf_pkg::MODE_SPLIT) && en_b && tick_b) begin
      {hi_b_d, lo_b_d} = step_b[15:0];
      set_tf_b = step_b[16];
      ovf_b_evt = step_b[16];
    end

    // Software writes win over counting
    if (wr_i) begin
      unique case (addr_i)
        dtf_pkg::OFS_CNT_LO_A: lo_a_d = wdata_i;
        dtf_pkg::OFS_CNT_HI_A: hi_a_d = wdata_i;
        dtf_pkg::OFS_CNT_LO_B: lo_b_d = wdata_i;
        dtf_pkg::OFS_CNT_HI_B: hi_b_d = wdata_i;
        dtf_pkg::OFS_CTRL: ctrl_d = wdata_i;
        dtf_pkg::OFS_MODE: mode_d = wdata_i;
        dtf_pkg::OFS_SCALE: scale_d = wdata_i;
        dtf_pkg::OFS_IRQ_MASK: mask_d = wdata_i;
        dtf_pkg::OFS_EXT_CFG: ext_cfg_d = wdata_i;
        default: ctrl_d = ctrl_q;
      endcase
    end

    // Hardware set beats a same-cycle clear
    if (set_tf_a) begin
      ctrl_d[dtf_pkg::CTRL_TF_A] = 1'b1;
    end
    if (set_tf_b) begin
      ctrl_d[dtf_pkg::CTRL_TF_B] = 1'b1;
    end
    ovf_b_d = ovf_b_evt;
  end

  // Read mux, data only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        dtf_pkg::OFS_CNT_LO_A: rdata_d = lo_a_q;
        dtf_pkg::OFS_CNT_HI_A: rdata_d = hi_a_q;
        dtf_pkg::OFS_CNT_LO_B: rdata_d = lo_b_q;
        dtf_pkg::OFS_CNT_HI_B: rdata_d = hi_b_q;
        dtf_pkg::OFS_CTRL: rdata_d = ctrl_q;
        dtf_pkg::OFS_MODE: rdata_d = mode_q;
        dtf_pkg::OFS_SCALE: rdata_d = scale_q;
        dtf_pkg::OFS_IRQ_MASK: rdata_d = mask_q;
        dtf_pkg::OFS_EXT_CFG: rdata_d = ext_cfg_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ******************************************************************
  // Registers
  // ******************************************************************

  // All state flops
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lo_a_q <= dtf_pkg::RST_BYTE;
      hi_a_q <= dtf_pkg::RST_BYTE;
      lo_b_q <= dtf_pkg::RST_BYTE;
      hi_b_q <= dtf_pkg::RST_BYTE;
      ctrl_q <= dtf_pkg::RST_BYTE;
      mode_q <= dtf_pkg::RST_BYTE;
      scale_q <= dtf_pkg::RST_BYTE;
      mask_q <= dtf_pkg::RST_BYTE;
      ext_cfg_q <= dtf_pkg::RST_BYTE;
      rdata_q <= dtf_pkg::RST_BYTE;
      ovf_b_q <= 1'b0;
    end else begin
      lo_a_q <= lo_a_d;
      hi_a_q <= hi_a_d;
      lo_b_q <= lo_b_d;
      hi_b_q <= hi_b_d;
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      scale_q <= scale_d;
      mask_q <= mask_d;
      ext_cfg_q <= ext_cfg_d;
      rdata_q <= rdata_d;
      ovf_b_q <= ovf_b_d;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************

  // Requests follow flag and enable bit
  assign irq_req_a_o = ctrl_q[dtf_pkg::CTRL_TF_A] &
                       mask_q[dtf_pkg::MASK_ALLOW_A];
  assign irq_req_b_o = ctrl_q[dtf_pkg::CTRL_TF_B] &
                       mask_q[dtf_pkg::MASK_ALLOW_B];
  assign ovf_b_o = ovf_b_q;
  assign rdata_o = rdata_q;

endmodule

/* include/dtf_pkg.sv */
// Purpose: Constants shared by the dual timer block
// Assumes: 8-bit register port, 10 MHz system clock
// Notes: Offsets are word indexes on the plain register port

package dtf_pkg;

  // ******************************************************************
  // Register offsets
  // ******************************************************************
  localparam logic [3:0] OFS_CNT_LO_A = 4'h0;
  localparam logic [3:0] OFS_CNT_HI_A = 4'h1;
  localparam logic [3:0] OFS_CNT_LO_B = 4'h2;
  localparam logic [3:0] OFS_CNT_HI_B = 4'h3;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_MODE = 4'h5;
  localparam logic [3:0] OFS_SCALE = 4'h6;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h7;
  localparam logic [3:0] OFS_EXT_CFG = 4'h8;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int CTRL_TF_B = 7;
  localparam int CTRL_RUN_B = 6;
  localparam int CTRL_TF_A = 5;
  localparam int CTRL_RUN_A = 4;
  localparam int MODE_GATE_B = 7;
  localparam int MODE_CS_B = 6;
  localparam int MODE_SEL_B = 4;
  localparam int MODE_GATE_A = 3;
  localparam int MODE_CS_A = 2;
  localparam int MODE_SEL_A = 0;
  localparam int SCALE_SYS_B = 3;
  localparam int SCALE_SYS_A = 2;
  localparam int SCALE_PRE = 0;
  localparam int MASK_ALLOW_B = 3;
  localparam int MASK_ALLOW_A = 1;
  localparam int EXT_POL_B = 7;
  localparam int EXT_POL_A = 3;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ******************************************************************
  // Modes and prescale codes
  // ******************************************************************
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [1:0] PRE_DIV12 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV48 = 2'h2;
  localparam logic [1:0] PRE_EXT8 = 2'h3;

  // ******************************************************************
  // Division counts (terminal values)
  // ******************************************************************
  localparam logic [5:0] DIV12_LAST = 6'h0b;
  localparam logic [5:0] DIV4_LAST = 6'h03;
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [5:0] EXT8_LAST = 6'h07;

endpackage

/* rtl/dtf_edge_sync.sv */
// Purpose: Two-flop synchroniser with falling-edge detect
// Assumes: Inputs asynchronous to clk_sys_i
// Notes: Edge taken between second and third flop only
`timescale 1ns/10ps
module dtf_edge_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Raw inputs
  input wire logic [W-1:0] async_i,
  // Synchronised level and falling-edge pulse
  output logic [W-1:0] level_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] s1_q, s2_q, s3_q;
  logic [W-1:0] s1_d, s2_d, s3_d;

  // Shift chain next values
  always_comb begin
    s1_d = async_i;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Synchroniser flops
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // One pulse per high-to-low change
  assign level_o = s2_q;
  assign fall_o = s3_q & ~s2_q;

endmodule

/* rtl/dtf_prescaler.sv */
// Purpose: Shared prescaler for both timers
// Assumes: ext_fall_i is a synchronised one-cycle pulse
// Notes: tick_o is a one-cycle pulse
`timescale 1ns/10ps
module dtf_prescaler (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Control
  input wire logic [1:0] scale_i,
  input wire logic ext_fall_i,
  // Prescaled tick
  output logic tick_o
);

  logic [5:0] cnt_q, cnt_d;
  logic [5:0] last;
  logic adv;

  // Divide selection and counter step
  always_comb begin
    unique case (scale_i)
      dtf_pkg::PRE_DIV12: last = dtf_pkg::DIV12_LAST;
      dtf_pkg::PRE_DIV4: last = dtf_pkg::DIV4_LAST;
      dtf_pkg::PRE_DIV48: last = dtf_pkg::DIV48_LAST;
      dtf_pkg::PRE_EXT8: last = dtf_pkg::EXT8_LAST;
    endcase
    adv = (scale_i == dtf_pkg::PRE_EXT8) ? ext_fall_i : 1'b1;
    tick_o = adv && (cnt_q >= last);
    cnt_d = cnt_q;
    if (adv) begin
      cnt_d = (cnt_q >= last) ? 6'h00 : cnt_q + 6'h01;
    end
  end

  // Counter register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* verification/dtf_pins_model.sv */
// Purpose: Far-side model of the timer count, gate and clock pins
// Assumes: Driven from the bench through task calls
// Notes: Count pin levels are held at least three clocks
`timescale 1ns/10ps
module dtf_pins_model (
  // Clock
  input wire logic clk_sys_i,
  // Pins
  output logic count_pin_a_o,
  output logic count_pin_b_o,
  output logic gating_input_a_o,
  output logic gating_input_b_o,
  output logic ext_clk_o
);
  logic [1:0] div_q = 2'h0;

  // Idle pin levels
  initial begin
    count_pin_a_o = 1'b1;
    count_pin_b_o = 1'b1;
    gating_input_a_o = 1'b0;
    gating_input_b_o = 1'b0;
  end

  // Free-running external clock, four system clocks a period
  always @(posedge clk_sys_i) begin
    div_q <= div_q + 2'h1;
    ext_clk_o <= div_q[1];
  end

  // Falling edges on pin a, levels held long enough to sync
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      count_pin_a_o <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      count_pin_a_o <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask

  // Gate level of timer a
  task automatic set_gate(input logic g);
    @(posedge clk_sys_i);
    gating_input_a_o <= g;
  endtask

  // Falling edges on pin b, same spacing as pin a
  task automatic pulse_b(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      count_pin_b_o <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      count_pin_b_o <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask

  // Gate level of timer b
  task automatic set_gate_b(input logic g);
    @(posedge clk_sys_i);
    gating_input_b_o <= g;
  endtask
endmodule

/* verification/dtf_timers_sva.sv */
// Purpose: Port-level checks of the dual timer
// Assumes: Bound to dtf_timers
// Notes: Shadows track bits that only software changes
`timescale 1ns/10ps
module dtf_timers_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Requests
  input wire logic irq_req_a_o,
  input wire logic irq_req_b_o
);
  logic run_a_q;
  logic allow_a_q;
  logic allow_b_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // Shadow of run A and irq enable bits
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_a_q <= 1'b0;
      allow_a_q <= 1'b0;
      allow_b_q <= 1'b0;
    end else if (wr_i && addr_i == dtf_pkg::OFS_CTRL) begin
      run_a_q <= wdata_i[dtf_pkg::CTRL_RUN_A];
    end else if (wr_i && addr_i == dtf_pkg::OFS_IRQ_MASK) begin
      allow_a_q <= wdata_i[dtf_pkg::MASK_ALLOW_A];
      allow_b_q <= wdata_i[dtf_pkg::MASK_ALLOW_B];
    end
  end

  // ********
  // Sequences
  // ********
  sequence cfg_wr_s;
    wr_i && addr_i >= dtf_pkg::OFS_MODE && addr_i <= dtf_pkg::OFS_EXT_CFG;
  endsequence
  sequence gap_rd_s;
    !wr_i ##1 rd_i && addr_i == $past(addr_i, 2);
  endsequence
  sequence lo_a_idle_s;
    wr_i && addr_i == dtf_pkg::OFS_CNT_LO_A && !run_a_q ##1 !wr_i;
  endsequence

  // ********
  // Assertions
  // ********
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property (
    rd_i && addr_i > dtf_pkg::OFS_EXT_CFG |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  cfg_readback_a: assert property (
    cfg_wr_s ##1 gap_rd_s |=> rdata_o == $past(wdata_i, 3))
    else $error("config readback wrong");
  frozen_count_a: assert property (
    lo_a_idle_s ##1 rd_i && addr_i == dtf_pkg::OFS_CNT_LO_A
    |=> rdata_o == $past(wdata_i, 3))
    else $error("stopped count changed");
  irq_mask_a_a: assert property (irq_req_a_o |-> allow_a_q)
    else $error("irq a without enable");
  irq_mask_b_a: assert property (irq_req_b_o |-> allow_b_q)
    else $error("irq b without enable");
  irq_fall_a_a: assert property ($fell(irq_req_a_o) |-> $past(wr_i) &&
    ($past(addr_i) == dtf_pkg::OFS_CTRL ||
     $past(addr_i) == dtf_pkg::OFS_IRQ_MASK))
    else $error("irq a dropped without write");
  irq_fall_b_a: assert property ($fell(irq_req_b_o) |-> $past(wr_i) &&
    ($past(addr_i) == dtf_pkg::OFS_CTRL ||
     $past(addr_i) == dtf_pkg::OFS_IRQ_MASK))
    else $error("irq b dropped without write");
endmodule

/* verification/dtf_timers_tb_top.sv */
// Purpose: Self-checking bench of the dual timer
// Assumes: Register port tasks, pin model drives the pins
// Notes: Counts derive from loaded values and pin edges
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module dtf_timers_tb_top;
  logic clk_sys_i;
  logic rstn_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic pin_a;
  logic pin_b;
  logic gate_a;
  logic gate_b;
  logic ext_clk;
  logic irq_req_a_o;
  logic irq_req_b_o;
  logic ovf_b_o;
  logic [7:0] v;
  logic [7:0] w;
  int err_count;
  int checked;
  int divs[4] = '{12, 4, 48, 32};

  dtf_timers dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .count_pin_a_i(pin_a), .count_pin_b_i(pin_b),
    .gating_input_a_i(gate_a), .gating_input_b_i(gate_b),
    .ext_clk_i(ext_clk), .irq_req_a_o(irq_req_a_o),
    .irq_req_b_o(irq_req_b_o), .ovf_b_o(ovf_b_o));
  dtf_pins_model pins (.clk_sys_i(clk_sys_i), .count_pin_a_o(pin_a),
    .count_pin_b_o(pin_b), .gating_input_a_o(gate_a),
    .gating_input_b_o(gate_b), .ext_clk_o(ext_clk));

  // Clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // ********
  // Register port tasks
  // ********
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_o;
  endtask
  task automatic chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(100 * 20000);
    err_count++;
    end_sim;
  end

  // ********
  // Tests
  // ********
  initial begin
    rstn_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    for (int a = 0; a < 10; a++) chk(a[3:0], 8'h00);
    for (int a = 5; a < 9; a++) begin
      wr(a[3:0], 8'h5a);
      chk(a[3:0], 8'h5a);
      wr(a[3:0], 8'h00);
    end
    // Mode 1 on system clock, wrap from all ones
    wr(dtf_pkg::OFS_SCALE, 8'h04);
    wr(dtf_pkg::OFS_MODE, 8'h01);
    wr(dtf_pkg::OFS_CNT_LO_A, 8'hff);
    wr(dtf_pkg::OFS_CNT_HI_A, 8'hff);
    wr(dtf_pkg::OFS_IRQ_MASK, 8'h02);
    wr(dtf_pkg::OFS_CTRL, 8'h10);
    chk(dtf_pkg::OFS_CTRL, 8'h30);
    chk(dtf_pkg::OFS_CNT_HI_A, 8'h00);
    `CHK(irq_req_a_o, 1'b1)
    wr(dtf_pkg::OFS_IRQ_MASK, 8'h00);
    @(negedge clk_sys_i);
    `CHK(irq_req_a_o, 1'b0)
    wr(dtf_pkg::OFS_CTRL, 8'h00);
    // Mode 0 counting pin edges across the 13-bit wrap
    wr(dtf_pkg::OFS_SCALE, 8'h00);
    wr(dtf_pkg::OFS_MODE, 8'h04);
    wr(dtf_pkg::OFS_CNT_LO_A, 8'hfe);
    wr(dtf_pkg::OFS_CNT_HI_A, 8'hff);
    wr(dtf_pkg::OFS_CTRL, 8'h10);
    pins.pulse(1);
    rd(dtf_pkg::OFS_CNT_LO_A, v);
    `CHK(v & 8'h1f, 8'h1f)
    pins.pulse(1);
    rd(dtf_pkg::OFS_CNT_LO_A, v);
    `CHK(v & 8'h1f, 8'h00)
    chk(dtf_pkg::OFS_CNT_HI_A, 8'h00);
    chk(dtf_pkg::OFS_CTRL, 8'h30);
    wr(dtf_pkg::OFS_CTRL, 8'h00);
    // Gated pin counting, gate active high
    wr(dtf_pkg::OFS_EXT_CFG, 8'h08);
    wr(dtf_pkg::OFS_MODE, 8'h0d);
    wr(dtf_pkg::OFS_CNT_LO_A, 8'h00);
    chk(dtf_pkg::OFS_CNT_LO_A, 8'h00);
    wr(dtf_pkg::OFS_CTRL, 8'h10);
    pins.pulse(2);
    chk(dtf_pkg::OFS_CNT_LO_A, 8'h00);
    pins.set_gate(1'b1);
    pins.pulse(2);
    chk(dtf_pkg::OFS_CNT_LO_A, 8'h02);
    wr(dtf_pkg::OFS_CTRL, 8'h00);
    pins.set_gate(1'b0);
    wr(dtf_pkg::OFS_EXT_CFG, 8'h00);
    // Mode 2 reload on pin edges
    wr(dtf_pkg::OFS_MODE, 8'h06);
    wr(dtf_pkg::OFS_CNT_LO_A, 8'hfe);
    wr(dtf_pkg::OFS_CNT_HI_A, 8'ha0);
    wr(dtf_pkg::OFS_CTRL, 8'h10);
    pins.pulse(3);
    chk(dtf_pkg::OFS_CNT_LO_A, 8'ha1);
    chk(dtf_pkg::OFS_CNT_HI_A, 8'ha0);
    chk(dtf_pkg::OFS_CTRL, 8'h30);
    wr(dtf_pkg::OFS_CTRL, 8'h00);
    // Timer B mode 1 on pin b edges, gate active high
    wr(dtf_pkg::OFS_EXT_CFG, 8'h80);
    wr(dtf_pkg::OFS_MODE, 8'hd0);
    wr(dtf_pkg::OFS_CNT_LO_B, 8'hfe);
    wr(dtf_pkg::OFS_CNT_HI_B, 8'hff);
    wr(dtf_pkg::OFS_IRQ_MASK, 8'h08);
    wr(dtf_pkg::OFS_CTRL, 8'h40);
    pins.pulse_b(1);
    chk(dtf_pkg::OFS_CNT_LO_B, 8'hfe);
    pins.set_gate_b(1'b1);
    pins.pulse_b(2);
    chk(dtf_pkg::OFS_CNT_LO_B, 8'h00);
    chk(dtf_pkg::OFS_CNT_HI_B, 8'h00);
    chk(dtf_pkg::OFS_CTRL, 8'hc0);
    `CHK(irq_req_b_o, 1'b1)
    wr(dtf_pkg::OFS_CTRL, 8'h00);
    wr(dtf_pkg::OFS_IRQ_MASK, 8'h00);
    pins.set_gate_b(1'b0);
    wr(dtf_pkg::OFS_EXT_CFG, 8'h00);
    // Every prescale code
    wr(dtf_pkg::OFS_MODE, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(dtf_pkg::OFS_SCALE, {6'h00, c[1:0]});
      wr(dtf_pkg::OFS_CNT_LO_A, 8'h00);
      wr(dtf_pkg::OFS_CTRL, 8'h10);
      repeat (4 * divs[c]) @(posedge clk_sys_i);
      wr(dtf_pkg::OFS_CTRL, 8'h00);
      rd(dtf_pkg::OFS_CNT_LO_A, v);
      `CHK(v >= 8'h03 && v <= 8'h05, 1'b1)
    end
    // Split mode
    wr(dtf_pkg::OFS_CNT_LO_B, 8'h1f);
    wr(dtf_pkg::OFS_CNT_HI_B, 8'hff);
    wr(dtf_pkg::OFS_SCALE, 8'h0c);
    wr(dtf_pkg::OFS_MODE, 8'h07);
    for (int i = 0; i < 40 && ovf_b_o !== 1'b1; i++) @(negedge clk_sys_i);
    `CHK(ovf_b_o, 1'b1)
    chk(dtf_pkg::OFS_CTRL, 8'h00);
    wr(dtf_pkg::OFS_IRQ_MASK, 8'h08);
    wr(dtf_pkg::OFS_CNT_HI_A, 8'hff);
    wr(dtf_pkg::OFS_CTRL, 8'h40);
    chk(dtf_pkg::OFS_CTRL, 8'hc0);
    `CHK(irq_req_b_o, 1'b1)
    wr(dtf_pkg::OFS_CNT_LO_A, 8'h00);
    wr(dtf_pkg::OFS_CTRL, 8'h50);
    pins.pulse(2);
    chk(dtf_pkg::OFS_CNT_LO_A, 8'h02);
    wr(dtf_pkg::OFS_MODE, 8'h37);
    rd(dtf_pkg::OFS_CNT_LO_B, v);
    rd(dtf_pkg::OFS_CNT_LO_B, w);
    `CHK(w, v)
    wr(dtf_pkg::OFS_CTRL, 8'h00);
    wr(dtf_pkg::OFS_IRQ_MASK, 8'h00);
    end_sim;
  end
endmodule

bind dtf_timers dtf_timers_chk chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_req_a_o(irq_req_a_o), .irq_req_b_o(irq_req_b_o));
